// ---- rtl/fifo_flag_pkg.sv ----
// Shared constants for the nine-bit FIFO with status flags
package fifo_flag_pkg;
    localparam int DATA_W = 9;
    localparam int PTR_W = 8;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] FIFO_DEPTH = 9'h100;
    // Bus map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] AE_OFFSET_OFS = 8'h04;
    localparam logic [7:0] AF_OFFSET_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] INT_STATUS_OFS = 8'h10;
    localparam logic [7:0] INT_MASK_OFS = 8'h14;
    // Control and status fields
    localparam int CTRL_FLUSH_BIT = 0;
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_EMPTY_BIT = 16;
    localparam int STAT_FULL_BIT = 17;
    localparam int STAT_AE_BIT = 18;
    localparam int STAT_AF_BIT = 19;
    // Interrupt event bits
    localparam int INT_W = 6;
    localparam int EVT_EMPTY = 0;
    localparam int EVT_FULL = 1;
    localparam int EVT_AEMPTY = 2;
    localparam int EVT_AFULL = 3;
    localparam int EVT_OVERFLOW = 4;
    localparam int EVT_UNDERFLOW = 5;
    // Reset values
    localparam logic [CNT_W-1:0] AE_OFFSET_RST = 9'h007;
    localparam logic [CNT_W-1:0] AF_OFFSET_RST = 9'h007;
    localparam logic [INT_W-1:0] INT_MASK_RST = 6'h00;
endpackage : fifo_flag_pkg

// ---- rtl/fifo_flag_regs.sv ----
// Registered status flags of the FIFO, computed from the next fill level
`timescale 1ns/1ns
module fifo_flag_regs
    import fifo_flag_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Next fill level and offsets
    input wire logic [fifo_flag_pkg::CNT_W-1:0] cnt_next,
    input wire logic [fifo_flag_pkg::CNT_W-1:0] ae_off_next,
    input wire logic [fifo_flag_pkg::CNT_W-1:0] af_off_next,
    // Flags about to be taken
    output logic empty_n_next,
    output logic full_n_next,
    output logic ae_n_next,
    output logic af_n_next,
    // Registered flags
    output logic empty_n_reg,
    output logic full_n_reg,
    output logic ae_n_reg,
    output logic af_n_reg
);
    import fifo_flag_pkg::*;

    // Low means the condition holds
    always_comb begin
        empty_n_next = (cnt_next != '0);
        full_n_next = (cnt_next != FIFO_DEPTH);
        ae_n_next = !(cnt_next < ae_off_next);
        af_n_next = (cnt_next <= FIFO_DEPTH - af_off_next);
    end

    // Working from the next level makes each flag move on the very edge that moves the level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            empty_n_reg <= 1'b0;
            full_n_reg <= 1'b1;
            ae_n_reg <= 1'b0;
            af_n_reg <= 1'b1;
        end else begin
            empty_n_reg <= empty_n_next;
            full_n_reg <= full_n_next;
            ae_n_reg <= ae_n_next;
            af_n_reg <= af_n_next;
        end
    end
endmodule : fifo_flag_regs

// ---- rtl/fifo_flag_top.sv ----
// Nine-bit FIFO with active-low status flags and an AHB-Lite register slave
`timescale 1ns/1ns
module fifo_flag_top
    import fifo_flag_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Writer side
    input wire logic WR_EN,
    input wire logic [fifo_flag_pkg::DATA_W-1:0] WR_DATA,
    // Reader side
    input wire logic RD_EN,
    output logic [fifo_flag_pkg::DATA_W-1:0] RD_DATA,
    output logic RD_VALID,
    // Status flags, active low
    output logic EMPTY_FLAG_N,
    output logic FULL_FLAG_N,
    output logic ALMOST_EMPTY_FLAG_N,
    output logic ALMOST_FULL_FLAG_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Interrupt
    output logic IRQ
);
    import fifo_flag_pkg::*;

    logic [DATA_W-1:0] mem_reg [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W-1:0] ae_off_reg;
    logic [CNT_W-1:0] ae_off_next;
    logic [CNT_W-1:0] af_off_reg;
    logic [CNT_W-1:0] af_off_next;
    logic [INT_W-1:0] int_status_reg;
    logic [INT_W-1:0] int_status_next;
    logic [INT_W-1:0] int_mask_reg;
    logic [INT_W-1:0] int_mask_next;
    logic [INT_W-1:0] events;
    logic flush_reg;
    logic wr_accept;
    logic rd_accept;
    logic empty_n_next;
    logic full_n_next;
    logic ae_n_next;
    logic af_n_next;
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic addr_phase;
    logic bus_wr;

    // Data path
    assign wr_accept = WR_EN && (count_reg != FIFO_DEPTH) && !flush_reg;
    assign rd_accept = RD_EN && (count_reg != '0) && !flush_reg;

    always_comb begin
        count_next = count_reg;
        if (flush_reg) begin
            count_next = '0;
        end else if (wr_accept && !rd_accept) begin
            count_next = count_reg + 9'h001;
        end else if (rd_accept && !wr_accept) begin
            count_next = count_reg - 9'h001;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
            if (flush_reg) begin
                wr_ptr_reg <= '0;
                rd_ptr_reg <= '0;
            end else begin
                if (wr_accept) begin
                    wr_ptr_reg <= wr_ptr_reg + 8'h01;
                end
                if (rd_accept) begin
                    rd_ptr_reg <= rd_ptr_reg + 8'h01;
                end
            end
        end
    end

    // Storage has no reset; a word is never read before it is written
    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_entry
        always_ff @(posedge CLK_SYS) begin
            if (wr_accept && (wr_ptr_reg == PTR_W'(i))) begin
                mem_reg[i] <= WR_DATA;
            end
        end
    end

    // Read data is registered so a word written into empty is out one period later
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            RD_DATA <= '0;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= rd_accept;
            if (rd_accept) begin
                RD_DATA <= mem_reg[rd_ptr_reg];
            end
        end
    end

    fifo_flag_regs u_flags (
        .clk(CLK_SYS),
        .rstn(RESETN),
        .cnt_next(count_next),
        .ae_off_next(ae_off_next),
        .af_off_next(af_off_next),
        .empty_n_next(empty_n_next),
        .full_n_next(full_n_next),
        .ae_n_next(ae_n_next),
        .af_n_next(af_n_next),
        .empty_n_reg(EMPTY_FLAG_N),
        .full_n_reg(FULL_FLAG_N),
        .ae_n_reg(ALMOST_EMPTY_FLAG_N),
        .af_n_reg(ALMOST_FULL_FLAG_N)
    );

    // Bus address and data phases; the slave never waits
    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign bus_wr = dp_valid_reg && dp_write_reg;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= '0;
            HREADYOUT <= 1'b0;
            HRESP <= 1'b0;
        end else begin
            dp_valid_reg <= addr_phase;
            dp_write_reg <= HWRITE;
            dp_addr_reg <= HADDR[7:0];
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    function automatic logic [CNT_W-1:0] clamp_offset(input logic [31:0] wdata);
        logic [CNT_W-1:0] v;
        v = (wdata[31:CNT_W] != '0) ? FIFO_DEPTH : wdata[CNT_W-1:0];
        return (v > FIFO_DEPTH) ? FIFO_DEPTH : v;
    endfunction : clamp_offset

    always_comb begin
        ae_off_next = ae_off_reg;
        af_off_next = af_off_reg;
        int_mask_next = int_mask_reg;
        if (bus_wr && dp_addr_reg == AE_OFFSET_OFS) begin
            ae_off_next = clamp_offset(HWDATA);
        end
        if (bus_wr && dp_addr_reg == AF_OFFSET_OFS) begin
            af_off_next = clamp_offset(HWDATA);
        end
        if (bus_wr && dp_addr_reg == INT_MASK_OFS) begin
            int_mask_next = HWDATA[INT_W-1:0];
        end
    end

    // Events: a flag falling, or a request refused at a boundary
    always_comb begin
        events = '0;
        events[EVT_EMPTY] = EMPTY_FLAG_N && !empty_n_next;
        events[EVT_FULL] = FULL_FLAG_N && !full_n_next;
        events[EVT_AEMPTY] = ALMOST_EMPTY_FLAG_N && !ae_n_next;
        events[EVT_AFULL] = ALMOST_FULL_FLAG_N && !af_n_next;
        events[EVT_OVERFLOW] = WR_EN && (count_reg == FIFO_DEPTH) && !flush_reg;
        events[EVT_UNDERFLOW] = RD_EN && (count_reg == '0) && !flush_reg;
        int_status_next = int_status_reg;
        if (bus_wr && dp_addr_reg == INT_STATUS_OFS) begin
            int_status_next = int_status_reg & ~HWDATA[INT_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        int_status_next = int_status_next | events;
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ae_off_reg <= AE_OFFSET_RST;
            af_off_reg <= AF_OFFSET_RST;
            int_mask_reg <= INT_MASK_RST;
            int_status_reg <= '0;
            flush_reg <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            ae_off_reg <= ae_off_next;
            af_off_reg <= af_off_next;
            int_mask_reg <= int_mask_next;
            int_status_reg <= int_status_next;
            flush_reg <= bus_wr && (dp_addr_reg == CTRL_OFS) && HWDATA[CTRL_FLUSH_BIT];
            IRQ <= |(int_status_next & int_mask_next);
        end
    end

    // Read data is taken at the address phase; status may move one cycle before it is seen
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            HRDATA <= '0;
        end else if (addr_phase && !HWRITE) begin
            HRDATA <= '0;
            unique case (HADDR[7:0])
                AE_OFFSET_OFS: HRDATA[CNT_W-1:0] <= ae_off_reg;
                AF_OFFSET_OFS: HRDATA[CNT_W-1:0] <= af_off_reg;
                STATUS_OFS: begin
                    HRDATA[STAT_CNT_LSB +: CNT_W] <= count_reg;
                    HRDATA[STAT_EMPTY_BIT] <= EMPTY_FLAG_N;
                    HRDATA[STAT_FULL_BIT] <= FULL_FLAG_N;
                    HRDATA[STAT_AE_BIT] <= ALMOST_EMPTY_FLAG_N;
                    HRDATA[STAT_AF_BIT] <= ALMOST_FULL_FLAG_N;
                end
                INT_STATUS_OFS: HRDATA[INT_W-1:0] <= int_status_reg;
                INT_MASK_OFS: HRDATA[INT_W-1:0] <= int_mask_reg;
                default: HRDATA <= '0;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    a_first_word_out: assert property (
        (count_reg == '0 && wr_accept && !flush_reg) ##1 RD_EN
        |=> RD_VALID && RD_DATA == $past(WR_DATA, 2))
        else $error("first word not delivered one period after write");
    a_full_same_cycle: assert property (
        (count_reg == FIFO_DEPTH - 9'h001) && wr_accept && !rd_accept |=> !FULL_FLAG_N)
        else $error("full flag late");
    a_ae_moves_level: assert property (
        !$stable(ALMOST_EMPTY_FLAG_N) |-> !$stable(count_reg) || !$stable(ae_off_reg))
        else $error("almost-empty moved without a level change");
    a_af_moves_level: assert property (
        !$stable(ALMOST_FULL_FLAG_N) |-> !$stable(count_reg) || !$stable(af_off_reg))
        else $error("almost-full moved without a level change");
    a_ae_threshold: assert property (
        $fell(ALMOST_EMPTY_FLAG_N) && $stable(ae_off_reg)
        |-> count_reg == ae_off_reg - 9'h001 || count_reg == '0)
        else $error("almost-empty fell at wrong level");
    a_ae_level: assert property (
        ALMOST_EMPTY_FLAG_N == (count_reg >= ae_off_reg))
        else $error("almost-empty disagrees with its offset");
    a_af_threshold: assert property (
        $fell(ALMOST_FULL_FLAG_N) && $stable(af_off_reg)
        |-> count_reg == FIFO_DEPTH - af_off_reg + 9'h001)
        else $error("almost-full fell at wrong level");
    a_af_level: assert property (
        ALMOST_FULL_FLAG_N == (count_reg <= FIFO_DEPTH - af_off_reg))
        else $error("almost-full disagrees with depth minus offset");
    a_empty_same_cycle: assert property (
        count_reg == '0 && wr_accept |=> EMPTY_FLAG_N)
        else $error("empty flag late");
    a_read_after_empty: assert property (
        $rose(EMPTY_FLAG_N) && RD_EN |=> RD_VALID)
        else $error("word not readable after empty released");
    a_flags_low_true: assert property (
        (EMPTY_FLAG_N == (count_reg != '0)) && (FULL_FLAG_N == (count_reg != FIFO_DEPTH)))
        else $error("flag polarity wrong");
    a_irq_follows: assert property (
        IRQ == |(int_status_reg & int_mask_reg))
        else $error("interrupt out of step with status");
    // Refused requests leave a sticky mark even when software clears in the same cycle
    a_overflow_seen: assert property (
        WR_EN && count_reg == FIFO_DEPTH && !flush_reg |=> int_status_reg[EVT_OVERFLOW])
        else $error("refused write left no overflow mark");
    a_underflow_seen: assert property (
        RD_EN && count_reg == '0 && !flush_reg |=> int_status_reg[EVT_UNDERFLOW])
        else $error("refused read left no underflow mark");
    a_flush_empties: assert property (
        flush_reg |=> count_reg == '0 && !EMPTY_FLAG_N)
        else $error("flush left words behind");
    a_count_bound: assert property (
        count_reg <= FIFO_DEPTH)
        else $error("fill level beyond depth");
    a_ptr_gap: assert property (
        count_reg[PTR_W-1:0] == wr_ptr_reg - rd_ptr_reg)
        else $error("fill level out of step with pointers");
    a_rd_data_held: assert property (
        !RD_VALID |-> $stable(RD_DATA))
        else $error("read word changed without a read");
    a_bus_okay: assert property (
        $past(RESETN) |-> HREADYOUT && !HRESP)
        else $error("bus slave stalled or erred");

    c_fill_full: cover property (!FULL_FLAG_N);
    c_full_read: cover property (!FULL_FLAG_N && RD_EN);
    c_write_empty_read: cover property ($rose(EMPTY_FLAG_N) ##1 RD_VALID);
    c_ae_fall: cover property ($fell(ALMOST_EMPTY_FLAG_N));
    c_irq: cover property ($rose(IRQ));
endmodule : fifo_flag_top

// ---- sim/dual_clock_fifo_flag_logic_bench.sv ----
// Self-checking bench for the FIFO status flags
`timescale 1ns/1ns
module dual_clock_fifo_flag_logic_bench;
    import fifo_flag_pkg::*;
    localparam int DEPTH = int'(FIFO_DEPTH);
    logic CLK_SYS, RESETN, WR_EN, RD_EN, RD_VALID, IRQ, HSEL, HWRITE, HREADYOUT, HRESP;
    logic EMPTY_FLAG_N, FULL_FLAG_N, ALMOST_EMPTY_FLAG_N, ALMOST_FULL_FLAG_N;
    logic [DATA_W-1:0] WR_DATA, RD_DATA, exp_rd;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic wr_go, rd_go, chk, exp_rv;
    logic [DATA_W-1:0] q[$];
    int cnt, n, m, num_errors, compares, seed;

    fifo_flag_top i_dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
        .RD_EN(RD_EN), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .EMPTY_FLAG_N(EMPTY_FLAG_N),
        .FULL_FLAG_N(FULL_FLAG_N), .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N),
        .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ));
    fifo_peer_model i_peer (.clk(CLK_SYS), .rstn(RESETN), .wr_go(wr_go), .rd_go(rd_go),
        .wr_en(WR_EN), .wr_data(WR_DATA), .rd_en(RD_EN));

    function automatic logic [3:0] exp_flags(input int c, input int an, input int fm);
        exp_flags = {c != 0, c != DEPTH, an == 0 || c >= an, fm == 0 || c < DEPTH + 1 - fm};
    endfunction : exp_flags

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic cyc(input logic we, input logic re);
        wr_go <= we;
        rd_go <= re;
        @(posedge CLK_SYS);
    endtask : cyc

    // Bus master: hold each phase until HREADYOUT is sampled high
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= wr;
        do begin @(posedge CLK_SYS); k++; end while (HREADYOUT !== 1'b1 && k < 20);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do begin @(posedge CLK_SYS); k++; end while (HREADYOUT !== 1'b1 && k < 20);
        rd = HRDATA;
        if (k >= 20) begin
            num_errors++;
            wrap_up();
        end
    endtask : ahb

    // Reference count and order, judged at every edge against the last edge's outputs; flags only at edges where chk is set
    always @(posedge CLK_SYS) begin
        if (RESETN) begin
            if (chk) begin
                check({28'h0, EMPTY_FLAG_N, FULL_FLAG_N, ALMOST_EMPTY_FLAG_N, ALMOST_FULL_FLAG_N},
                    {28'h0, exp_flags(cnt, n, m)});
            end
            check({31'h0, RD_VALID}, {31'h0, exp_rv});
            if (exp_rv) check({23'h0, RD_DATA}, {23'h0, exp_rd});
            exp_rv = RD_EN && cnt != 0;
            if (exp_rv) exp_rd = q.pop_front();
            if (WR_EN && cnt != DEPTH) q.push_back(WR_DATA);
            cnt = cnt + int'(WR_EN && cnt != DEPTH) - int'(exp_rv);
        end
    end

    initial begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end

    initial begin
        RESETN = 1'b0; wr_go = 1'b0; rd_go = 1'b0; HSEL = 1'b0; HTRANS = 2'h0;
        HADDR = 32'h0; HWRITE = 1'b0; HWDATA = 32'h0; chk = 1'b1; exp_rv = 1'b0;
        cnt = 0; n = 7; m = 7; num_errors = 0; compares = 0;
        seed = $urandom(32'h970C);
        repeat (4) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        repeat (2) cyc(1'b0, 1'b0);
        check({30'h0, IRQ, HRESP}, 32'h0);
        $display("test reset done");
        // Short walk out of empty and straight back in
        cyc(1'b1, 1'b0);
        repeat (3) cyc(1'b0, 1'b1);
        repeat (2) cyc(1'b0, 1'b0);
        $display("test first word done");
        chk <= 1'b0;
        cyc(1'b0, 1'b0);
        n = 1 + $urandom % 16;
        m = 1 + $urandom % 16;
        ahb(1'b1, {24'h0, AE_OFFSET_OFS}, n);
        ahb(1'b1, {24'h0, AF_OFFSET_OFS}, m);
        repeat (2) cyc(1'b0, 1'b0);
        chk <= 1'b1;
        ahb(1'b0, {24'h0, AF_OFFSET_OFS}, 32'h0);
        check(rd, m);
        ahb(1'b0, 32'h0000_0040, 32'h0);
        check(rd, 32'h0);
        $display("test offsets done");
        // Fill past full, then drain past empty, every level judged on the way
        repeat (DEPTH + 2) cyc(1'b1, 1'b0);
        cyc(1'b1, 1'b1);
        repeat (DEPTH + 2) cyc(1'b0, 1'b1);
        repeat (2) cyc(1'b0, 1'b0);
        $display("test fill and drain done");
        ahb(1'b0, {24'h0, INT_STATUS_OFS}, 32'h0);
        check(rd & 32'h30, 32'h30);
        check({31'h0, IRQ}, 32'h0);
        ahb(1'b1, {24'h0, INT_MASK_OFS}, 32'h10);
        cyc(1'b0, 1'b0);
        check({31'h0, IRQ}, 32'h1);
        ahb(1'b1, {24'h0, INT_STATUS_OFS}, 32'h3F);
        cyc(1'b0, 1'b0);
        check({31'h0, IRQ}, 32'h0);
        $display("test interrupt done");
        // Flush with words inside; the model restarts empty once the flush has landed
        repeat (5) cyc(1'b1, 1'b0);
        cyc(1'b0, 1'b0);
        chk <= 1'b0;
        ahb(1'b1, {24'h0, CTRL_OFS}, 32'h1);
        repeat (2) cyc(1'b0, 1'b0);
        cnt = 0;
        q.delete();
        chk <= 1'b1;
        ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0);
        check(rd, 32'h000A_0000);
        $display("test flush done");
        repeat (700) cyc($urandom % 4 != 0, $urandom % 3 == 0);
        repeat (700) cyc($urandom % 3 == 0, $urandom % 4 != 0);
        repeat (2) cyc(1'b0, 1'b0);
        $display("test random traffic done");
        wrap_up();
    end
endmodule : dual_clock_fifo_flag_logic_bench

// ---- sim/fifo_peer_model.sv ----
// Writer and reader logic that faces the FIFO ports
`timescale 1ns/1ns
module fifo_peer_model
    import fifo_flag_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Requests from the bench
    input wire logic wr_go,
    input wire logic rd_go,
    // FIFO ports
    output logic wr_en,
    output logic [fifo_flag_pkg::DATA_W-1:0] wr_data,
    output logic rd_en
);
    logic [DATA_W-1:0] seq_reg;

    // Idle data is inverted so a stale word is never mistaken for a fresh one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_en <= 1'b0;
            rd_en <= 1'b0;
            wr_data <= 9'h000;
            seq_reg <= 9'h0A5;
        end else begin
            wr_en <= wr_go;
            rd_en <= rd_go;
            seq_reg <= seq_reg + 9'h0C7;
            wr_data <= wr_go ? seq_reg : ~wr_data;
        end
    end
endmodule : fifo_peer_model
